// [rtl/mcrm_pkg.sv]
package mcrm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [15:0] MODE_OFF   = 16'h000b;
	localparam logic [15:0] RAM_POSITION_OFF = 16'h0010;
	localparam logic [15:0] REGBLOCK_POSITION_OFF = 16'h0011;
	localparam logic [15:0] EEPROM_POSITION_OFF = 16'h0012;
	localparam logic [15:0] STAT_OFF   = 16'h0013;
	localparam logic [15:0] PPAGE_OFF  = 16'h0030;
	localparam logic [15:0] PK_D_OFF   = 16'h0032;
	localparam logic [15:0] PK_DIR_OFF = 16'h0033;
	localparam logic [15:0] PE_D_OFF   = 16'h0008;
	localparam logic [15:0] PE_DIR_OFF = 16'h0009;

	// ----------------------------------------
	// Mode register fields
	// ----------------------------------------
	localparam int MB_SPECIAL_SELECT_N = 7;
	localparam int MB_MODE_SELECT_HI  = 6;
	localparam int MB_MODE_SELECT_LO  = 5;
	localparam int MB_ECLK_STRETCH_EN  = 4;
	localparam int MB_INTERNAL_VISIBILITY  = 3;
	localparam int MB_EBSW  = 2;
	localparam int MB_EMK   = 1;
	localparam int MB_EME   = 0;

	localparam logic [1:0] MS_SINGLE = 2'h0;
	localparam logic [1:0] MS_NARROW = 2'h1;
	localparam logic [1:0] MS_PERIPH = 2'h2;
	localparam logic [1:0] MS_WIDE   = 2'h3;

	// ----------------------------------------
	// Reset values and map windows
	// ----------------------------------------
	localparam logic [7:0]  RAM_POSITION_RST  = 8'h20;
	localparam logic [7:0]  REGBLOCK_POSITION_RST  = 8'h00;
	localparam logic [7:0]  EEPROM_POSITION_RST  = 8'h01;
	localparam logic [7:0]  RAM_POSITION_MASK = 8'he0;
	localparam logic [7:0]  REGBLOCK_POSITION_MASK = 8'hf9;
	localparam logic [7:0]  EEPROM_POSITION_MASK = 8'hf1;
	localparam logic [7:0]  PPAGE_MASK  = 8'h07;
	localparam logic [15:0] DBG_ROM_LO  = 16'hff20;
	localparam logic [15:0] DBG_REG_LO  = 16'hff00;
	localparam logic [15:0] DBG_REG_HI  = 16'hff06;
	localparam logic [15:0] FIX_LO_LO   = 16'h4000;
	localparam logic [15:0] FIX_HI_LO   = 16'hc000;
	localparam logic [15:0] WIN_LO      = 16'h8000;
	localparam int          WAIT_STOP_CYC = 4;

	// ----------------------------------------
	// Resource select
	// ----------------------------------------
	typedef enum logic [6:0] {
		MCRM_SEL_NONE = 7'h01,
		MCRM_SEL_DBG  = 7'h02,
		MCRM_SEL_REG  = 7'h04,
		MCRM_SEL_RAM  = 7'h08,
		MCRM_SEL_EE   = 7'h10,
		MCRM_SEL_FLSH = 7'h20,
		MCRM_SEL_EXT  = 7'h40
	} mcrm_sel_t;

	typedef enum logic [2:0] {
		MCRM_DBG_OFF = 3'h1,
		MCRM_DBG_EN  = 3'h2,
		MCRM_DBG_ACT = 3'h4
	} mcrm_dbg_t;

endpackage : mcrm_pkg

// [rtl/mcrm_top.sv]
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

module mcrm_top #(
	parameter int AW = 16
) (
	input  wire logic          clk_in,
	input  wire logic          resetn_in,
	input  wire logic          debug_pin_in,
	input  wire logic          mode_select_hi_in,
	input  wire logic          mode_select_lo_in,
	input  wire logic [AW-1:0] reg_addr_in,
	input  wire logic [7:0]    reg_wdata_in,
	input  wire logic          reg_wr_in,
	input  wire logic          reg_rd_in,
	output logic      [7:0]    reg_rdata_out,
	output logic               reg_hit_out,
	input  wire logic [AW-1:0] cpu_addr_in,
	input  wire logic          cpu_access_in,
	input  wire logic          debug_enable_in,
	input  wire logic          debug_cmd_in,
	input  wire logic          enter_debug_instr_in,
	input  wire logic          debug_exit_in,
	input  wire logic          wait_mode_in,
	input  wire logic          ext_bus_busy_in,
	output logic      [6:0]    resource_sel_out,
	output logic      [2:0]    flash_page_out,
	output logic               background_debug_out,
	output logic               eclk_stretch_out,
	output logic               visibility_out,
	output logic               vis_wide_out,
	output logic               ext_bus_stopped_out,
	output logic               pk_mapped_out,
	output logic               pe_mapped_out,
	output logic      [7:0]    mode_out
);

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	logic [7:0] mode_q;
	logic       first_wr_q;
	logic       once_mode_q;
	logic       once_eclk_stretch_en_q;
	logic       once_internal_visibility_q;
	logic       once_emk_q;
	logic       once_eme_q;
	logic       boot_q;
	logic       special;
	logic       expanded;
	logic       periph;
	logic       mode_wr;
	logic [1:0] ms_new;

	assign special  = ~mode_q[mcrm_pkg::MB_SPECIAL_SELECT_N];
	assign periph   = mode_q[6:5] == mcrm_pkg::MS_PERIPH;
	assign expanded = (mode_q[6:5] == mcrm_pkg::MS_NARROW) || (mode_q[6:5] == mcrm_pkg::MS_WIDE);
	assign mode_wr  = reg_wr_in && reg_addr_in == mcrm_pkg::MODE_OFF && !periph;
	assign ms_new   = reg_wdata_in[6:5];

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			mode_q      <= 8'h00;
			boot_q      <= 1'b1;
			first_wr_q  <= 1'b1;
			once_mode_q <= 1'b0;
			once_eclk_stretch_en_q <= 1'b0;
			once_internal_visibility_q <= 1'b0;
			once_emk_q  <= 1'b0;
			once_eme_q  <= 1'b0;
		end
		else if (boot_q)
		begin
			boot_q <= 1'b0;
			mode_q[mcrm_pkg::MB_SPECIAL_SELECT_N] <= debug_pin_in;
			mode_q[mcrm_pkg::MB_MODE_SELECT_HI]  <= mode_select_hi_in;
			mode_q[mcrm_pkg::MB_MODE_SELECT_LO]  <= mode_select_lo_in;
			mode_q[mcrm_pkg::MB_ECLK_STRETCH_EN]  <= 1'b1;
			mode_q[mcrm_pkg::MB_INTERNAL_VISIBILITY]  <= ~debug_pin_in;
			mode_q[mcrm_pkg::MB_EBSW]  <= 1'b0;
			mode_q[mcrm_pkg::MB_EMK]   <= ~debug_pin_in;
			mode_q[mcrm_pkg::MB_EME]   <= ~debug_pin_in;
			if (debug_pin_in && mode_select_hi_in && !mode_select_lo_in)
			begin
				mode_q[mcrm_pkg::MB_SPECIAL_SELECT_N] <= 1'b0;
			end
		end
		else if (mode_wr)
		begin
			first_wr_q <= 1'b0;
			if (special)
			begin
				if (!first_wr_q)
				begin
					mode_q[mcrm_pkg::MB_SPECIAL_SELECT_N] <= reg_wdata_in[mcrm_pkg::MB_SPECIAL_SELECT_N];
					if (ms_new != mcrm_pkg::MS_PERIPH)
					begin
						mode_q[6:5] <= ms_new;
					end
					mode_q[mcrm_pkg::MB_INTERNAL_VISIBILITY] <= reg_wdata_in[mcrm_pkg::MB_INTERNAL_VISIBILITY];
					mode_q[mcrm_pkg::MB_EMK]  <= reg_wdata_in[mcrm_pkg::MB_EMK];
					mode_q[mcrm_pkg::MB_EME]  <= reg_wdata_in[mcrm_pkg::MB_EME];
				end
				mode_q[mcrm_pkg::MB_ECLK_STRETCH_EN] <= reg_wdata_in[mcrm_pkg::MB_ECLK_STRETCH_EN];
			end
			else
			begin
				mode_q[mcrm_pkg::MB_EBSW] <= reg_wdata_in[mcrm_pkg::MB_EBSW];
				once_mode_q <= 1'b1;
				once_eclk_stretch_en_q <= 1'b1;
				once_internal_visibility_q <= 1'b1;
				once_emk_q  <= 1'b1;
				once_eme_q  <= 1'b1;
				if (!once_mode_q && ms_new != mcrm_pkg::MS_PERIPH)
				begin
					mode_q[6:5] <= ms_new;
				end
				if (!once_eclk_stretch_en_q)
				begin
					mode_q[mcrm_pkg::MB_ECLK_STRETCH_EN] <= reg_wdata_in[mcrm_pkg::MB_ECLK_STRETCH_EN];
				end
				if (!once_internal_visibility_q)
				begin
					mode_q[mcrm_pkg::MB_INTERNAL_VISIBILITY] <= reg_wdata_in[mcrm_pkg::MB_INTERNAL_VISIBILITY];
				end
				if (!once_emk_q)
				begin
					mode_q[mcrm_pkg::MB_EMK] <= reg_wdata_in[mcrm_pkg::MB_EMK];
				end
				if (!once_eme_q)
				begin
					mode_q[mcrm_pkg::MB_EME] <= reg_wdata_in[mcrm_pkg::MB_EME];
				end
			end
		end
	end

	// Stretch held at one while expanded
	logic eclk_stretch_en_eff;
	assign eclk_stretch_en_eff = mode_q[mcrm_pkg::MB_ECLK_STRETCH_EN] | expanded;

	// ----------------------------------------
	// Mapping registers
	// ----------------------------------------
	logic [7:0] ram_position_q;
	logic [7:0] regblock_position_q;
	logic [7:0] eeprom_position_q;
	logic [7:0] ppage_q;
	logic [2:0] map_once_q;

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			ram_position_q   <= mcrm_pkg::RAM_POSITION_RST;
			regblock_position_q   <= mcrm_pkg::REGBLOCK_POSITION_RST;
			eeprom_position_q   <= mcrm_pkg::EEPROM_POSITION_RST;
			ppage_q    <= 8'h00;
			map_once_q <= 3'h0;
		end
		else if (reg_wr_in && !boot_q)
		begin
			if (reg_addr_in == mcrm_pkg::RAM_POSITION_OFF && (special || !map_once_q[0]))
			begin
				ram_position_q      <= reg_wdata_in & mcrm_pkg::RAM_POSITION_MASK;
				map_once_q[0] <= !special;
			end
			if (reg_addr_in == mcrm_pkg::REGBLOCK_POSITION_OFF && (special || !map_once_q[1]))
			begin
				regblock_position_q      <= reg_wdata_in & mcrm_pkg::REGBLOCK_POSITION_MASK;
				map_once_q[1] <= !special;
			end
			if (reg_addr_in == mcrm_pkg::EEPROM_POSITION_OFF)
			begin
				if (special || !map_once_q[2])
				begin
					eeprom_position_q[7:4] <= reg_wdata_in[7:4];
					map_once_q[2] <= !special;
				end
				eeprom_position_q[0] <= reg_wdata_in[0];
			end
			if (reg_addr_in == mcrm_pkg::PPAGE_OFF)
			begin
				ppage_q <= reg_wdata_in & mcrm_pkg::PPAGE_MASK;
			end
		end
	end

	// ----------------------------------------
	// Debug state
	// ----------------------------------------
	mcrm_pkg::mcrm_dbg_t dbg_q;

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			dbg_q <= mcrm_pkg::MCRM_DBG_OFF;
		end
		else if (boot_q)
		begin
			if (!debug_pin_in && !mode_select_hi_in && !mode_select_lo_in)
			begin
				dbg_q <= mcrm_pkg::MCRM_DBG_ACT;
			end
		end
		else
		begin
			case (dbg_q)
				mcrm_pkg::MCRM_DBG_OFF:
				begin
					if (debug_enable_in)
					begin
						dbg_q <= mcrm_pkg::MCRM_DBG_EN;
					end
				end
				mcrm_pkg::MCRM_DBG_EN:
				begin
					if (debug_cmd_in || enter_debug_instr_in)
					begin
						dbg_q <= mcrm_pkg::MCRM_DBG_ACT;
					end
				end
				mcrm_pkg::MCRM_DBG_ACT:
				begin
					if (debug_exit_in)
					begin
						dbg_q <= mcrm_pkg::MCRM_DBG_EN;
					end
				end
				default:
				begin
					dbg_q <= mcrm_pkg::MCRM_DBG_OFF;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic            in_dbg;
	logic            in_reg;
	logic            in_ram;
	logic            in_ee;
	logic            in_fix;
	logic            in_win;
	logic [AW-1:0]   a;
	mcrm_pkg::mcrm_sel_t sel_d;

	assign a      = cpu_addr_in;
	assign in_dbg = dbg_q == mcrm_pkg::MCRM_DBG_ACT
		&& (a >= mcrm_pkg::DBG_ROM_LO || (a >= mcrm_pkg::DBG_REG_LO && a <= mcrm_pkg::DBG_REG_HI));
	assign in_reg = a[15:11] == regblock_position_q[7:3] && !a[10];
	assign in_ram = a[15:13] == ram_position_q[7:5];
	assign in_ee  = eeprom_position_q[0] && a[15:12] == eeprom_position_q[7:4] && a[11];
	assign in_fix = (a[15:14] == mcrm_pkg::FIX_LO_LO[15:14])
		|| (a[15:14] == mcrm_pkg::FIX_HI_LO[15:14]);
	assign in_win = a[15:14] == mcrm_pkg::WIN_LO[15:14];

	always_comb
	begin
		if (in_dbg)
			sel_d = mcrm_pkg::MCRM_SEL_DBG;
		else if (in_reg)
			sel_d = mcrm_pkg::MCRM_SEL_REG;
		else if (in_ram)
			sel_d = mcrm_pkg::MCRM_SEL_RAM;
		else if (in_ee)
			sel_d = mcrm_pkg::MCRM_SEL_EE;
		else if (in_fix || in_win)
			sel_d = mcrm_pkg::MCRM_SEL_FLSH;
		else if (expanded || periph)
			sel_d = mcrm_pkg::MCRM_SEL_EXT;
		else
			sel_d = mcrm_pkg::MCRM_SEL_NONE;
	end

	logic [6:0] sel_q;
	logic [2:0] page_q;

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			sel_q  <= mcrm_pkg::MCRM_SEL_NONE;
			page_q <= 3'h7;
		end
		else
		begin
			sel_q  <= sel_d;
			page_q <= in_win ? ppage_q[2:0] : {2'h3, a[15]};
		end
	end

	// ----------------------------------------
	// External bus control
	// ----------------------------------------
	logic [2:0] wait_cnt_q;
	logic       stopped_q;
	logic       stretch_q;
	logic       vis_q;
	logic       ext_acc;

	assign ext_acc = sel_d == mcrm_pkg::MCRM_SEL_EXT;

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			wait_cnt_q <= 3'h0;
			stopped_q  <= 1'b0;
		end
		else if (wait_mode_in && mode_q[mcrm_pkg::MB_EBSW] && !ext_bus_busy_in)
		begin
			if (wait_cnt_q == 3'(mcrm_pkg::WAIT_STOP_CYC))
				stopped_q <= 1'b1;
			else
				wait_cnt_q <= wait_cnt_q + 3'h1;
		end
		else
		begin
			wait_cnt_q <= 3'h0;
			stopped_q  <= 1'b0;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			stretch_q <= 1'b0;
			vis_q     <= 1'b0;
		end
		else
		begin
			stretch_q <= eclk_stretch_en_eff && cpu_access_in
				&& (ext_acc || !mode_q[mcrm_pkg::MB_INTERNAL_VISIBILITY]);
			vis_q <= mode_q[mcrm_pkg::MB_INTERNAL_VISIBILITY] && (expanded || periph)
				&& cpu_access_in && !ext_acc;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	logic pk_map;
	logic pe_map;
	logic hit_d;
	logic [7:0] rd_d;
	logic [7:0] rdata_q;
	logic       hit_q;

	assign pk_map = !(mode_q[mcrm_pkg::MB_EMK] && (expanded || periph));
	assign pe_map = !(mode_q[mcrm_pkg::MB_EME] && (expanded || periph));

	always_comb
	begin
		hit_d = 1'b1;
		rd_d  = 8'h00;
		case (reg_addr_in)
			mcrm_pkg::MODE_OFF:
			begin
				rd_d  = periph ? 8'h00 : {mode_q[7:5], eclk_stretch_en_eff, mode_q[3:0]};
				hit_d = !periph;
			end
			mcrm_pkg::RAM_POSITION_OFF: rd_d = ram_position_q;
			mcrm_pkg::REGBLOCK_POSITION_OFF: rd_d = regblock_position_q;
			mcrm_pkg::EEPROM_POSITION_OFF: rd_d = eeprom_position_q;
			mcrm_pkg::PPAGE_OFF:  rd_d = ppage_q;
			mcrm_pkg::STAT_OFF:   rd_d = {4'h0, stopped_q, dbg_q};
			mcrm_pkg::PK_D_OFF:   hit_d = pk_map;
			mcrm_pkg::PK_DIR_OFF: hit_d = pk_map;
			mcrm_pkg::PE_D_OFF:   hit_d = pe_map;
			mcrm_pkg::PE_DIR_OFF: hit_d = pe_map;
			default:              hit_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= reg_rd_in ? rd_d : 8'h00;
			hit_q   <= reg_rd_in && hit_d;
		end
	end

	assign reg_rdata_out        = rdata_q;
	assign reg_hit_out          = hit_q;
	assign resource_sel_out     = sel_q;
	assign flash_page_out       = page_q;
	assign background_debug_out = dbg_q == mcrm_pkg::MCRM_DBG_ACT;
	assign eclk_stretch_out     = stretch_q;
	assign visibility_out       = vis_q;
	assign vis_wide_out         = vis_q && special && mode_q[6:5] == mcrm_pkg::MS_NARROW;
	assign ext_bus_stopped_out  = stopped_q;
	assign pk_mapped_out        = pk_map;
	assign pe_mapped_out        = pe_map;
	assign mode_out             = {mode_q[7:5], eclk_stretch_en_eff, mode_q[3:0]};

endmodule : mcrm_top

// [sim/mcrm_checker.sv]
`timescale 1ns/1ps
module mcrm_checker #(
	parameter int AW = 16
) (
	input wire logic          clk_in,
	input wire logic          resetn_in,
	input wire logic [AW-1:0] reg_addr_in,
	input wire logic          reg_rd_in,
	input wire logic          reg_wr_in,
	input wire logic [7:0]    reg_rdata_out,
	input wire logic          reg_hit_out,
	input wire logic [AW-1:0] cpu_addr_in,
	input wire logic          cpu_access_in,
	input wire logic          wait_mode_in,
	input wire logic          ext_bus_busy_in,
	input wire logic [6:0]    resource_sel_out,
	input wire logic [2:0]    flash_page_out,
	input wire logic          vis_wide_out,
	input wire logic          background_debug_out,
	input wire logic          eclk_stretch_out,
	input wire logic          visibility_out,
	input wire logic          ext_bus_stopped_out,
	input wire logic          pk_mapped_out,
	input wire logic          pe_mapped_out,
	input wire logic [7:0]    mode_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	a_sel_onehot: assert property ($onehot(resource_sel_out))
		else $error("resource select not one-hot");
	a_dbg_rom_overlay: assert property (cpu_access_in && background_debug_out &&
		cpu_addr_in >= 16'hff20 |=> resource_sel_out == 7'h02)
		else $error("debug rom not selected");
	a_mode_readback: assert property (reg_rd_in && reg_addr_in == mcrm_pkg::MODE_OFF &&
		mode_out[7:5] != 3'h2 |=> reg_hit_out && reg_rdata_out == $past(mode_out))
		else $error("mode register read wrong");
	a_periph_absent: assert property (reg_rd_in && reg_addr_in == mcrm_pkg::MODE_OFF &&
		mode_out[7:5] == 3'h2 |=> !reg_hit_out)
		else $error("mode register seen in peripheral mode");
	a_no_periph_sel: assert property (reg_wr_in && mode_out[6:5] != 2'h2
		|=> mode_out[6:5] != 2'h2)
		else $error("peripheral mode selected by write");
	a_stretch_expanded: assert property (mode_out[5] && cpu_access_in && !mode_out[3]
		|=> eclk_stretch_out)
		else $error("stretch off in expanded mode");
	a_page_fixed: assert property (cpu_access_in && cpu_addr_in[15:14] == 2'h3
		|=> flash_page_out == 3'h7)
		else $error("fixed flash page wrong");
	a_vis_wide_mode: assert property (vis_wide_out
		|-> visibility_out && mode_out[7:5] == 3'h1)
		else $error("wide visibility outside special narrow");
	a_vis_single: assert property (mode_out[6:5] == 2'h0 && $past(mode_out[6:5], 2) == 2'h0
		|-> !visibility_out)
		else $error("visibility in single chip");
	a_ports_single: assert property (mode_out[6:5] == 2'h0 |-> pk_mapped_out && pe_mapped_out)
		else $error("port registers unmapped in single chip");
	a_bus_stop_wait: assert property ((wait_mode_in && mode_out[2] && !ext_bus_busy_in)[*8]
		|-> ext_bus_stopped_out)
		else $error("bus not stopped in wait");
	a_stop_cause: assert property ($rose(ext_bus_stopped_out) |-> $past(wait_mode_in) &&
		mode_out[2])
		else $error("bus stopped without wait");
endmodule : mcrm_checker

bind mcrm_top mcrm_checker #(.AW(AW)) i_mcrm_checker (.clk_in(clk_in), .resetn_in(resetn_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
	.reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out), .cpu_addr_in(cpu_addr_in),
	.cpu_access_in(cpu_access_in), .wait_mode_in(wait_mode_in),
	.ext_bus_busy_in(ext_bus_busy_in), .resource_sel_out(resource_sel_out),
	.flash_page_out(flash_page_out), .vis_wide_out(vis_wide_out),
	.background_debug_out(background_debug_out), .eclk_stretch_out(eclk_stretch_out),
	.visibility_out(visibility_out), .ext_bus_stopped_out(ext_bus_stopped_out),
	.pk_mapped_out(pk_mapped_out), .pe_mapped_out(pe_mapped_out), .mode_out(mode_out));

// [sim/mcrm_far_side.sv]
`timescale 1ns/1ps
module mcrm_far_side #(
	parameter int BUSY_CYC = 3
) (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic [7:0] mode_in,
	input  wire logic       cmd_req_in,
	input  wire logic       busy_go_in,
	output logic            debug_cmd_out,
	output logic            ext_bus_busy_out
);
	logic [3:0] busy_cnt_q;

	// ----------------------------------------
	// Debug host, silent in peripheral mode
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			debug_cmd_out <= 1'b0;
		else
			debug_cmd_out <= cmd_req_in && mode_in[7:5] != 3'h2;
	end

	// ----------------------------------------
	// External memory finishing last access
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			busy_cnt_q <= 4'h0;
		else if (busy_go_in)
			busy_cnt_q <= 4'(BUSY_CYC);
		else if (busy_cnt_q != 4'h0)
			busy_cnt_q <= busy_cnt_q - 4'h1;
	end

	assign ext_bus_busy_out = busy_cnt_q != 4'h0;
endmodule : mcrm_far_side

// [sim/mode_control_and_resource_map_test.sv]
`timescale 1ns/1ps
module mode_control_and_resource_map_test;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [2:0]  pins = 3'h7;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        acc = 1'b0;
	logic        waitm = 1'b0;
	logic        busy_go = 1'b0;
	logic [3:0]  dbg_p = 4'h0;
	logic        cmd;
	logic        busy;
	logic [7:0]  rdata;
	logic        hit;
	logic [6:0]  sel;
	logic        dbg_act;
	logic        stopped;
	logic [7:0]  mode;
	logic [8:0]  exp_q[$];
	logic        rd_d = 1'b0;
	int          err_total = 0;
	int          comparisons = 0;
	int unsigned seed_v;

	always #4 clk_in = ~clk_in;

	mcrm_top i_mcrm_top (.clk_in(clk_in), .resetn_in(resetn_in), .debug_pin_in(pins[2]),
		.mode_select_hi_in(pins[1]), .mode_select_lo_in(pins[0]), .reg_addr_in(reg_addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.reg_hit_out(hit), .cpu_addr_in(cpu_addr), .cpu_access_in(acc),
		.debug_enable_in(dbg_p[0]), .debug_cmd_in(cmd), .enter_debug_instr_in(dbg_p[2]),
		.debug_exit_in(dbg_p[3]), .wait_mode_in(waitm), .ext_bus_busy_in(busy),
		.resource_sel_out(sel), .flash_page_out(), .background_debug_out(dbg_act),
		.eclk_stretch_out(), .visibility_out(), .vis_wide_out(),
		.ext_bus_stopped_out(stopped), .pk_mapped_out(), .pe_mapped_out(), .mode_out(mode));

	mcrm_far_side i_mcrm_far_side (.clk_in(clk_in), .resetn_in(resetn_in), .mode_in(mode),
		.cmd_req_in(dbg_p[1]), .busy_go_in(busy_go), .debug_cmd_out(cmd),
		.ext_bus_busy_out(busy));

	// ----------------------------------------
	// Comparison and read monitor
	// ----------------------------------------
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	always @(posedge clk_in)
	begin
		rd_d <= rd;
		if (rd_d)
			check({hit, rdata}, exp_q.pop_front());
	end

	// ----------------------------------------
	// Bus and control tasks
	// ----------------------------------------
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		@(posedge clk_in);
	endtask : wr_reg

	task automatic rd_reg(input logic [15:0] a, input logic [8:0] e);
		reg_addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_in);
		rd <= 1'b0;
		@(posedge clk_in);
	endtask : rd_reg

	task automatic do_reset(input logic [2:0] p);
		resetn_in <= 1'b0;
		pins <= p;
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask : do_reset

	task automatic pulse(input int i);
		dbg_p[i] <= 1'b1;
		@(posedge clk_in);
		dbg_p[i] <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
	endtask : pulse

	task automatic probe(input logic [15:0] a, input logic [6:0] e);
		cpu_addr <= a;
		acc <= 1'b1;
		@(posedge clk_in);
		#1;
		check({2'h0, sel}, {2'h0, e});
		@(posedge clk_in);
	endtask : probe

	function automatic logic [8:0] reset_mode(input logic [2:0] p);
		logic [2:0] m;
		m = (p == 3'h6) ? 3'h2 : p;
		if (m == 3'h2)
			return 9'h000;
		return m[2] ? {1'b1, m, 5'h10} : {1'b1, m, 5'h1b};
	endfunction : reset_mode

	task automatic complete_run;
		$display("counts: comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		complete_run();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		seed_v = $urandom(32'h731e);
		for (int p = 0; p < 8; p++)
		begin
			do_reset(3'(p));
			rd_reg(mcrm_pkg::MODE_OFF, reset_mode(3'(p)));
			check({8'h00, dbg_act}, {8'h00, p == 0});
		end
		$display("test reset modes done");
		do_reset(3'h7);
		wr_reg(mcrm_pkg::MODE_OFF, 8'hf8);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h1f8);
		wr_reg(mcrm_pkg::MODE_OFF, 8'hf0);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h1f8);
		wr_reg(mcrm_pkg::MODE_OFF, 8'hf4);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h1fc);
		rd_reg(16'h0020, 9'h000);
		waitm <= 1'b1;
		busy_go <= 1'b1;
		@(posedge clk_in);
		busy_go <= 1'b0;
		for (int n = 0; n < 30 && stopped !== 1'b1; n++)
			@(posedge clk_in);
		check({8'h00, stopped}, 9'h001);
		waitm <= 1'b0;
		$display("test normal writes done");
		do_reset(3'h1);
		wr_reg(mcrm_pkg::MODE_OFF, 8'h31);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h13b);
		wr_reg(mcrm_pkg::MODE_OFF, 8'h31);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h131);
		wr_reg(mcrm_pkg::MODE_OFF, 8'h55);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h131);
		wr_reg(mcrm_pkg::MODE_OFF, 8'h21);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h131);
		wr_reg(mcrm_pkg::MODE_OFF, 8'h09);
		rd_reg(mcrm_pkg::MODE_OFF, 9'h109);
		$display("test special writes done");
		do_reset(3'h4);
		repeat (4) probe(16'h4000 | 16'($urandom & 32'h3fff), 7'h20);
		pulse(0);
		pulse(2);
		check({8'h00, dbg_act}, 9'h001);
		repeat (4) probe(16'hff20 | 16'($urandom & 32'h00df), 7'h02);
		pulse(3);
		check({8'h00, dbg_act}, 9'h000);
		pulse(1);
		check({8'h00, dbg_act}, 9'h001);
		acc <= 1'b0;
		$display("test debug done");
		complete_run();
	end
endmodule : mode_control_and_resource_map_test
